// [shared/pst_pkg.sv]
// Constants shared by the protection stage timer: register map, fields, resets, timing.
package pst_pkg;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_PICKUP     = 8'h04;
  localparam logic [7:0] REG_UBLOCK     = 8'h08;
  localparam logic [7:0] REG_DEF_DELAY  = 8'h0c;
  localparam logic [7:0] REG_TIME_DIAL  = 8'h10;
  localparam logic [7:0] REG_EXPONENT   = 8'h14;
  localparam logic [7:0] REG_REL_DELAY  = 8'h18;
  localparam logic [7:0] REG_VT_SCALE   = 8'h1c;
  localparam logic [7:0] REG_STATUS     = 8'h20;
  localparam logic [7:0] REG_EXPECTED   = 8'h24;
  localparam logic [7:0] REG_REMAINING  = 8'h28;
  localparam logic [7:0] REG_RATIO_PCT  = 8'h2c;
  localparam logic [7:0] REG_RATIO_Q10  = 8'h30;
  localparam logic [7:0] REG_PRIM_PICK  = 8'h34;
  // Control register fields.
  localparam int CTRL_INV_BIT    = 0;
  localparam int CTRL_UNDER_BIT  = 1;
  localparam int CTRL_DREL_BIT   = 2;
  localparam int CTRL_RSTAFT_BIT = 3;
  localparam int CTRL_CONT_BIT   = 4;
  localparam int CTRL_W          = 5;
  localparam logic [4:0] CTRL_RESET = 5'h0c;
  // Status register fields.
  localparam int ST_START_BIT   = 0;
  localparam int ST_TRIP_BIT    = 1;
  localparam int ST_BLOCKED_BIT = 2;
  localparam int ST_PICKUP_BIT  = 3;
  localparam int ST_INHIBIT_BIT = 4;
  // Timing: one program cycle is 5 ms, counts are in program cycles.
  localparam int CLK_PERIOD_NS  = 20;
  localparam int CYCLE_NS       = 5000000;
  localparam int CYCLE_CLKS     = CYCLE_NS / CLK_PERIOD_NS;
  localparam int STEP_MS        = 5;
  localparam int DEF_DELAY_MS   = 40;
  localparam int REL_DELAY_MS   = 60;
  localparam int MAX_TIME_MS    = 1800000;
  localparam int TW             = 20;
  localparam logic [TW-1:0] DEF_DELAY_RESET = TW'(DEF_DELAY_MS / STEP_MS);
  localparam logic [TW-1:0] REL_DELAY_RESET = TW'(REL_DELAY_MS / STEP_MS);
  localparam logic [TW-1:0] MAX_TIME_CYCLES = TW'(MAX_TIME_MS / STEP_MS);
  // Levels in 0.01 %Un, dial and exponent in 0.01 units.
  localparam int VW = 16;
  localparam logic [VW-1:0] PICKUP_RESET  = 16'h2904;
  localparam logic [VW-1:0] UBLOCK_RESET  = 16'h01f4;
  localparam logic [VW-1:0] DIAL_RESET    = 16'h0005;
  localparam logic [VW-1:0] EXP_RESET     = 16'h0064;
  localparam logic [19:0]   VT_RESET      = 20'h186a0;
  localparam int            HYST_OVER_PCT  = 97;
  localparam int            HYST_UNDER_PCT = 103;
  localparam int            PCT_ONE       = 100;
  localparam int            LEVEL_FULL    = 10000;
  localparam int            Q_ONE         = 1024;
  localparam int            Q_SHIFT       = 10;
  localparam int            CYC_PER_DIAL  = 2;
  localparam logic [31:0]   POW_SAT       = 32'h00ff_ffff;
endpackage

// [rtl/pst_top.sv]
// Operating-time and blocking logic of one sequence-voltage protection stage.
// Operation
// - Blocking sampled once per program cycle.
// - Pick-up without blocking asserts start, times.
// - Pick-up under blocking asserts blocked only.
// - Blocking during start acts as pick-up reset.
// - Instant mode trips together with start.
// - Definite mode trips after delay, magnitude-independent.
// - Inverse mode uses k over ratio-power formula.
// - Delay type selects definite/inverse, definite default.
// - Definite delay 5 ms steps, 40 ms default.
// - Dial and exponent 0.01 steps, inverse only.
// - Release delay 5 ms steps, 60 ms.
// - Delayed release holds start until release expires.
// - Timer reset after release, else immediately.
// - Continue mode keeps counting during release.
// - No trip during release without renewed pick-up.
// - Default: 60 ms release, counter held.
// - Remaining time published in 5 ms steps.
// - Inverse expected time recomputed every cycle.
// - Measured-to-set ratios published read-only.
// - Primary pick-up voltage published, 0.1 V.
// - Release at 97 % over, 103 % under.
// - Direction setting selects over or under.
// - Under-block level inhibits trip until lines recover.
`timescale 1ns/10ps
`default_nettype none
module pst_top
  import pst_pkg::*;
#(
  parameter int CYCLE_CLOCKS = CYCLE_CLKS
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Avalon-MM slave.
  input  wire logic [7:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  // Measurement and blocking inputs.
  input  wire logic [VW-1:0] measured_voltage_i,
  input  wire logic [VW-1:0] line_min_voltage_i,
  input  wire logic          block_i,
  // Stage outputs.
  output logic               start_o,
  output logic               trip_o,
  output logic               blocked_o
);
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_DIV   = 3'b001,
    M_RATIO = 3'b010,
    M_EXPO  = 3'b011,
    M_POW   = 3'b100,
    M_FRAC  = 3'b101,
    M_TIME  = 3'b110,
    M_PRIM  = 3'b111
  } pst_math_type;

  // Input synchronisers.
  logic [VW-1:0] um_m_q, um_q, lm_m_q, lm_q;
  logic          blk_m_q, blk_q;
  always_ff @(posedge clk_i) begin
    um_m_q  <= measured_voltage_i;
    um_q    <= um_m_q;
    lm_m_q  <= line_min_voltage_i;
    lm_q    <= lm_m_q;
    blk_m_q <= block_i;
    blk_q   <= blk_m_q;
  end

  // Program cycle tick.
  logic [31:0] cyc_cnt_q;
  logic        tick;
  assign tick = (cyc_cnt_q == 32'(CYCLE_CLOCKS - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      cyc_cnt_q <= '0;
    end else begin
      cyc_cnt_q <= cyc_cnt_q + 32'h1;
    end
  end

  // Settings registers.
  logic [CTRL_W-1:0] ctrl_q;
  logic [VW-1:0]     pickup_q, ublock_q, dial_q, expo_q;
  logic [TW-1:0]     def_delay_q, rel_delay_q;
  logic [19:0]       vt_q;
  logic              wr_en;
  assign wr_en = avs_write_i && !avs_waitrequest_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q      <= CTRL_RESET;
      pickup_q    <= PICKUP_RESET;
      ublock_q    <= UBLOCK_RESET;
      def_delay_q <= DEF_DELAY_RESET;
      dial_q      <= DIAL_RESET;
      expo_q      <= EXP_RESET;
      rel_delay_q <= REL_DELAY_RESET;
      vt_q        <= VT_RESET;
    end else if (wr_en) begin
      case (avs_address_i)
        REG_CTRL:      ctrl_q      <= avs_writedata_i[CTRL_W-1:0];
        REG_PICKUP:    pickup_q    <= avs_writedata_i[VW-1:0];
        REG_UBLOCK:    ublock_q    <= avs_writedata_i[VW-1:0];
        REG_DEF_DELAY: def_delay_q <= avs_writedata_i[TW-1:0];
        REG_TIME_DIAL: dial_q      <= avs_writedata_i[VW-1:0];
        REG_EXPONENT:  expo_q      <= avs_writedata_i[VW-1:0];
        REG_REL_DELAY: rel_delay_q <= avs_writedata_i[TW-1:0];
        REG_VT_SCALE:  vt_q        <= avs_writedata_i[19:0];
        default: ;
      endcase
    end
  end

  logic inv_mode, under_mode;
  assign inv_mode   = ctrl_q[CTRL_INV_BIT];
  assign under_mode = ctrl_q[CTRL_UNDER_BIT];

  // Pick-up comparison with built-in hysteresis.
  logic [31:0] um_x100, us_x_over, us_x_under;
  logic        pick_act_q, inhibit_q;
  assign um_x100    = 32'(um_q) * 32'(PCT_ONE);
  assign us_x_over  = 32'(pickup_q) * 32'(HYST_OVER_PCT);
  assign us_x_under = 32'(pickup_q) * 32'(HYST_UNDER_PCT);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pick_act_q <= 1'b0;
    end else if (tick) begin
      if (!under_mode) begin
        pick_act_q <= pick_act_q ? (um_x100 >= us_x_over) : (um_q > pickup_q);
      end else begin
        pick_act_q <= pick_act_q ? (um_x100 <= us_x_under) : (um_q < pickup_q);
      end
    end
  end

  // A dead network must not trip an undervoltage stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inhibit_q <= 1'b0;
    end else if (tick) begin
      if (!under_mode || ublock_q == '0) begin
        inhibit_q <= 1'b0;
      end else if (um_q < ublock_q) begin
        inhibit_q <= 1'b1;
      end else if (lm_q > pickup_q) begin
        inhibit_q <= 1'b0;
      end
    end
  end

  // Sequential arithmetic, rerun every program cycle on one shared divider.
  pst_math_type mst_q, ret_q;
  logic [31:0]  dq_q, dr_q, dd_q, pw_q, ratio_q;
  logic [5:0]   dcnt_q;
  logic [4:0]   pcnt_q;
  logic [6:0]   frac_q;
  logic [TW-1:0] inv_time_q;
  logic [31:0]  ratio_pct_q, prim_q;
  logic [32:0]  dtmp;
  logic [63:0]  pw_prod;
  logic signed [47:0] fr, pw_f, den;
  assign dtmp    = {dr_q, dq_q[31]};
  assign pw_prod = 64'(pw_q) * 64'(ratio_q);
  always_comb begin
    fr   = (48'(signed'({1'b0, frac_q})) * 48'sd41
           * (48'(signed'({1'b0, ratio_q})) - 48'(Q_ONE))) >>> 12;
    pw_f = (48'(signed'({1'b0, pw_q})) * (48'(Q_ONE) + fr)) >>> Q_SHIFT;
    den  = under_mode ? (48'(Q_ONE) - pw_f) : (pw_f - 48'(Q_ONE));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mst_q <= M_IDLE;
      ret_q <= M_IDLE;
      dq_q <= '0; dr_q <= '0; dd_q <= '0; dcnt_q <= '0;
      pw_q <= '0; pcnt_q <= '0; frac_q <= '0; ratio_q <= '0;
      ratio_pct_q <= '0; prim_q <= '0;
      inv_time_q  <= MAX_TIME_CYCLES;
    end else begin
      case (mst_q)
        M_IDLE: if (tick) begin
          dq_q <= 32'(um_q) << Q_SHIFT;
          dr_q <= '0; dd_q <= 32'(pickup_q); dcnt_q <= '0;
          ret_q <= M_RATIO; mst_q <= M_DIV;
        end
        M_DIV: begin
          if (dtmp >= {1'b0, dd_q}) begin
            dr_q <= 32'(dtmp - {1'b0, dd_q});
            dq_q <= {dq_q[30:0], 1'b1};
          end else begin
            dr_q <= dtmp[31:0];
            dq_q <= {dq_q[30:0], 1'b0};
          end
          dcnt_q <= dcnt_q + 6'h1;
          if (dcnt_q == 6'h1f) begin
            mst_q <= ret_q;
          end
        end
        M_RATIO: begin
          ratio_q     <= dq_q;
          ratio_pct_q <= 32'((64'(dq_q) * 64'(PCT_ONE)) >> Q_SHIFT);
          dq_q <= 32'(expo_q); dr_q <= '0; dd_q <= 32'(PCT_ONE); dcnt_q <= '0;
          ret_q <= M_EXPO; mst_q <= M_DIV;
        end
        M_EXPO: begin
          pcnt_q <= dq_q[4:0];
          frac_q <= dr_q[6:0];
          pw_q   <= 32'(Q_ONE);
          mst_q  <= M_POW;
        end
        M_POW: begin
          if (pcnt_q == '0) begin
            mst_q <= M_FRAC;
          end else begin
            pw_q   <= (pw_prod[63:42] != '0) ? POW_SAT : pw_prod[41:10];
            pcnt_q <= pcnt_q - 5'h1;
          end
        end
        M_FRAC: begin
          dr_q <= '0; dcnt_q <= '0;
          if (den <= 48'sd0) begin
            dq_q <= 32'hffff_ffff; dd_q <= 32'h1;
            mst_q <= M_TIME;
          end else begin
            dq_q <= 32'(dial_q) * 32'(CYC_PER_DIAL * Q_ONE);
            dd_q <= den[31:0];
            ret_q <= M_TIME; mst_q <= M_DIV;
          end
        end
        M_TIME: begin
          inv_time_q <= (dq_q > 32'(MAX_TIME_CYCLES)) ? MAX_TIME_CYCLES : dq_q[TW-1:0];
          dq_q <= 32'(pickup_q) * 32'(vt_q);
          dr_q <= '0; dd_q <= 32'(LEVEL_FULL); dcnt_q <= '0;
          ret_q <= M_PRIM; mst_q <= M_DIV;
        end
        M_PRIM: begin
          prim_q <= dq_q;
          mst_q  <= M_IDLE;
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end

  // Operating and release timers.
  logic [TW-1:0] expected, op_cnt_q, rel_cnt_q;
  logic          releasing_q, start_q, trip_q, blocked_q, eff_pickup;
  assign expected   = inv_mode ? inv_time_q : def_delay_q;
  assign eff_pickup = pick_act_q && !blk_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blocked_q <= 1'b0;
    end else if (tick) begin
      blocked_q <= pick_act_q && blk_q;
    end
  end

  // Every timer moves only on the program cycle tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0; trip_q <= 1'b0; releasing_q <= 1'b0;
      op_cnt_q <= '0; rel_cnt_q <= '0;
    end else if (tick) begin
      if (eff_pickup) begin
        start_q     <= 1'b1;
        releasing_q <= 1'b0;
        rel_cnt_q   <= '0;
        if (op_cnt_q >= expected) begin
          trip_q <= !inhibit_q;
        end else begin
          op_cnt_q <= op_cnt_q + 1'b1;
          trip_q   <= 1'b0;
        end
      end else begin
        trip_q <= 1'b0;
        if (start_q && !releasing_q) begin
          // Pick-up lost or blocking arrived: enter the release interval.
          releasing_q <= (rel_delay_q != '0);
          rel_cnt_q   <= '0;
          start_q     <= ctrl_q[CTRL_DREL_BIT] && (rel_delay_q != '0) && !blk_q;
          if (!ctrl_q[CTRL_RSTAFT_BIT] || rel_delay_q == '0) begin
            op_cnt_q <= '0;
          end else if (ctrl_q[CTRL_CONT_BIT]) begin
            op_cnt_q <= op_cnt_q + 1'b1;
          end
        end else if (releasing_q) begin
          rel_cnt_q <= rel_cnt_q + 1'b1;
          if (rel_cnt_q + 1'b1 >= rel_delay_q) begin
            releasing_q <= 1'b0;
            start_q     <= 1'b0;
            op_cnt_q    <= '0;
          end else begin
            start_q <= start_q && !blk_q;
            if (ctrl_q[CTRL_CONT_BIT] && op_cnt_q < MAX_TIME_CYCLES) begin
              op_cnt_q <= op_cnt_q + 1'b1;
            end
          end
        end else begin
          start_q  <= 1'b0;
          op_cnt_q <= '0;
        end
      end
    end
  end

  assign start_o   = start_q;
  assign trip_o    = trip_q;
  assign blocked_o = blocked_q;

  // Bus answer: one wait cycle, then read data and waitrequest low together.
  logic [31:0] rd_mux, remaining;
  logic        wait_q;
  logic [31:0] rd_q;
  assign remaining = (start_q && !trip_q)
                   ? 32'(signed'({1'b0, expected}) - signed'({1'b0, op_cnt_q}))
                   : '0;
  always_comb begin
    case (avs_address_i)
      REG_CTRL:      rd_mux = 32'(ctrl_q);
      REG_PICKUP:    rd_mux = 32'(pickup_q);
      REG_UBLOCK:    rd_mux = 32'(ublock_q);
      REG_DEF_DELAY: rd_mux = 32'(def_delay_q);
      REG_TIME_DIAL: rd_mux = 32'(dial_q);
      REG_EXPONENT:  rd_mux = 32'(expo_q);
      REG_REL_DELAY: rd_mux = 32'(rel_delay_q);
      REG_VT_SCALE:  rd_mux = 32'(vt_q);
      REG_STATUS:    rd_mux = 32'({inhibit_q, pick_act_q, blocked_q, trip_q, start_q});
      REG_EXPECTED:  rd_mux = 32'(expected);
      REG_REMAINING: rd_mux = remaining;
      REG_RATIO_PCT: rd_mux = ratio_pct_q;
      REG_RATIO_Q10: rd_mux = ratio_q;
      REG_PRIM_PICK: rd_mux = prim_q;
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
      rd_q   <= '0;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
      rd_q   <= avs_read_i ? rd_mux : '0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rd_q;
endmodule
`default_nettype wire

// [testbench/pst_sva.sv]
// Port-level assertions for the protection stage timer.
`timescale 1ns/10ps
`default_nettype none
module pst_sva
  import pst_pkg::*;
#(
  parameter int CYCLE_CLOCKS = CYCLE_CLKS
) (
  // Clock and reset.
  input wire logic          clk_i,
  input wire logic          rst_i,
  // Register bus.
  input wire logic [7:0]    avs_address_i,
  input wire logic          avs_read_i,
  input wire logic          avs_write_i,
  input wire logic [31:0]   avs_writedata_i,
  input wire logic [31:0]   avs_readdata_o,
  input wire logic          avs_waitrequest_o,
  // Stage link.
  input wire logic [VW-1:0] measured_voltage_i,
  input wire logic [VW-1:0] line_min_voltage_i,
  input wire logic          block_i,
  input wire logic          start_o,
  input wire logic          trip_o,
  input wire logic          blocked_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_WAIT_ANS: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer missing");
  AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  AST_RST_CLEAR: assert property ($fell(rst_i) |-> !start_o && !trip_o && !blocked_o
    && avs_waitrequest_o) else $error("outputs not cleared by reset");
  AST_BLK_EXCL: assert property (!(start_o && blocked_o))
    else $error("start and blocked together");
  AST_BLK_CAUSE: assert property ($rose(blocked_o) |-> $past(block_i, 2) || $past(block_i, 3)
    || $past(block_i, 4) || $past(block_i, 5)) else $error("blocked without block input");
  AST_TRIP_START: assert property ($rose(trip_o) |-> start_o)
    else $error("trip without start");
  AST_START_HOLD: assert property (!$stable(start_o) |=> $stable(start_o) [*8])
    else $error("start changed off the program cycle");
  AST_TRIP_HOLD: assert property (!$stable(trip_o) |=> $stable(trip_o) [*8])
    else $error("trip changed off the program cycle");
  cover property ($rose(trip_o));
  cover property ($rose(blocked_o));
  cover property ($fell(start_o));
endmodule
bind pst_top pst_sva #(.CYCLE_CLOCKS(CYCLE_CLOCKS)) u_pst_sva (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .measured_voltage_i(measured_voltage_i),
  .line_min_voltage_i(line_min_voltage_i), .block_i(block_i), .start_o(start_o),
  .trip_o(trip_o), .blocked_o(blocked_o));
`default_nettype wire

// [testbench/pst_far_model.sv]
// Behavioural pick-up source and blocking matrix facing the stage.
`timescale 1ns/10ps
`default_nettype none
module pst_far_model
  import pst_pkg::*;
(
  // Clock.
  input  wire logic          clk_i,
  // Conditions requested by the bench.
  input  wire logic [VW-1:0] level_i,
  input  wire logic [VW-1:0] line_i,
  input  wire logic          blk_i,
  // Far-side signals.
  output logic      [VW-1:0] measured_voltage_o,
  output logic      [VW-1:0] line_min_voltage_o,
  output logic               block_o
);
  // Sources refresh on the clock; the bench raises blocking only while the definite delay is set to zero.
  always_ff @(posedge clk_i) begin
    measured_voltage_o <= level_i;
    line_min_voltage_o <= line_i;
    block_o            <= blk_i;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the protection stage timer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pst_pkg::*;
  localparam int CYC = 200;
  logic clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, blk = 1'b0, wreq, st, tr, bl, bk;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [VW-1:0] lvl = 16'h2710, lin = 16'h2710, mv, lm;
  int err_total = 0, cmp_count = 0, n;
  time t0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{32'h0c, 32'h2904, 32'h1f4, 32'h8, 32'h5, 32'h64, 32'hc, 32'h186a0};
  pst_top #(.CYCLE_CLOCKS(CYC)) u_pst_top (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .measured_voltage_i(mv), .line_min_voltage_i(lm), .block_i(bk),
    .start_o(st), .trip_o(tr), .blocked_o(bl));
  pst_far_model u_pst_far_model (.clk_i(clk_i), .level_i(lvl), .line_i(lin), .blk_i(blk),
    .measured_voltage_o(mv), .line_min_voltage_o(lm), .block_o(bk));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waitrequest and read data are taken at the rising edge, as the slave sees them.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a; wdata <= d; rd <= !w; wr <= w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdata;
    if (wreq !== 1'b0) chk("bus answer", 32'h1, 32'h0);
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic setv(input logic [VW-1:0] v, input logic b);
    @(posedge clk_i);
    lvl <= v; lin <= v; blk <= b;
  endtask
  task automatic wait_for(input int s, input logic v);
    n = 0;
    while ((s == 0 ? st : s == 1 ? tr : bl) !== v && n < 40 * CYC) begin
      @(negedge clk_i);
      n++;
    end
    if ((s == 0 ? st : s == 1 ? tr : bl) !== v) chk("wait for output", {31'h0, v}, {31'h0, !v});
  endtask
  task automatic ticks(input int k);
    repeat (k * CYC) @(posedge clk_i);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rdchk("reset value", ra[i], rv[i]);
    bus(1'b1, 8'h28, 32'h5);
    rdchk("read-only remaining", REG_REMAINING, 32'h0);
    bus(1'b1, 8'h3c, 32'h7);
    rdchk("unmapped", 8'h3c, 32'h0);
    $display("test registers done");
    setv(16'h283c, 1'b0);
    ticks(15);
    chk("start below set", 32'h0, {31'h0, st});
    setv(16'h2af8, 1'b0);
    wait_for(0, 1'b1);
    t0 = $time;
    bus(1'b0, REG_REMAINING, 32'h0);
    chk("remaining in range", 32'h1, {31'h0, q != 0 && q <= 8});
    wait_for(1, 1'b1);
    chk("definite delay", 8 * CYC, 32'(($time - t0) / CLK_PERIOD_NS));
    setv(16'h283c, 1'b0);
    ticks(15);
    chk("hysteresis hold", 32'h3, {30'h0, tr, st});
    setv(16'h2710, 1'b0);
    wait_for(1, 1'b0);
    wait_for(0, 1'b0);
    chk("release delay", 32'h1, {31'h0, n >= 10 * CYC && n <= 13 * CYC});
    $display("test definite done");
    bus(1'b1, REG_DEF_DELAY, 32'h0);
    setv(16'h2af8, 1'b0);
    wait_for(0, 1'b1);
    chk("instant trip", 32'h1, {31'h0, tr});
    setv(16'h2710, 1'b0);
    wait_for(0, 1'b0);
    bus(1'b1, REG_CTRL, 32'h08);
    setv(16'h2af8, 1'b0);
    wait_for(0, 1'b1);
    setv(16'h2710, 1'b0);
    wait_for(0, 1'b0);
    chk("undelayed release", 32'h1, {31'h0, n <= 3 * CYC});
    $display("test instant and release done");
    setv(16'h2af8, 1'b1);
    ticks(6);
    chk("blocked only", 32'h4, {29'h0, bl, tr, st});
    setv(16'h2af8, 1'b0);
    wait_for(0, 1'b1);
    chk("start after unblock", 32'h1, {31'h0, n <= 4 * CYC});
    setv(16'h2af8, 1'b1);
    wait_for(2, 1'b1);
    chk("start dropped by block", 32'h0, {31'h0, st});
    setv(16'h2710, 1'b0);
    ticks(3);
    $display("test blocking done");
    bus(1'b1, REG_CTRL, 32'h0d);
    setv(16'h5208, 1'b0);
    wait_for(0, 1'b1);
    ticks(3);
    rdchk("expected ratio 2", REG_EXPECTED, 32'd10);
    rdchk("ratio q10", REG_RATIO_Q10, 32'd2048);
    setv(16'h3d86, 1'b0);
    ticks(4);
    rdchk("expected ratio 1.5", REG_EXPECTED, 32'd20);
    rdchk("ratio pct", REG_RATIO_PCT, 32'd150);
    rdchk("primary pickup", REG_PRIM_PICK, 32'd105000);
    setv(16'h2710, 1'b0);
    ticks(15);
    bus(1'b1, REG_CTRL, 32'h0a);
    setv(16'h2328, 1'b0);
    wait_for(0, 1'b1);
    chk("under pickup", 32'h1, {31'h0, st});
    setv(16'h0100, 1'b0);
    ticks(3);
    chk("under inhibit", 32'h1, {30'h0, tr, st});
    $display("test inverse and under done");
    report_and_stop();
  end
  initial begin
    #(20 * 60000);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
